// *** src/power_device_info_store.sv ***
// Command-addressed identity, rating and user data store behind an SMBus target
`default_nettype none

// Contract
// - Revision byte: link [7:5], language [4:0]
// - Revision may be read-only
// - Block transfers lead with a byte count
// - Count byte also consumes inventory pool
// - Variable-length entries bounded by pool size
// - Six inventory strings stored and returned
// - Ratings carry exactly two data bytes
// - Ratings never enforced nor flagged
// - Ten rating words writable and readable
// - Sixteen user blocks, 255 bytes each (only USER_IMPL built, default 2; others flagged unsupported)
// - Forty-six maker codes, defined by maker
// - Maker escape uses extended transactions
// - Protocol escape reserved, same forms
// - Unsupported command sets invalid-command flag
// - Bad data sets invalid-data flag
module power_device_info_store #(
    parameter int INV_POOL = 128,
    parameter int USER_IMPL = 2,
    parameter int USER_BYTES = 255,
    parameter bit REV_READ_ONLY = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic xfer_start,
    input wire logic [7:0] xfer_cmd,
    input wire logic xfer_write,
    input wire logic wr_valid,
    input wire logic [7:0] wr_byte,
    input wire logic xfer_stop,
    input wire logic rd_req,
    output logic rd_valid,
    output logic [7:0] rd_byte,
    output logic cmd_hit,
    input wire logic cml_clear,
    output logic [7:0] cml_flags
);
    import info_store_pkg::*;

    localparam int SLOT = INV_POOL - 1;
    localparam int DEPTH = NUM_STR * SLOT + USER_IMPL * USER_BYTES;
    localparam int AW = $clog2(DEPTH);

    if (INV_POOL < 2 || INV_POOL > 256 || USER_IMPL < 1 || USER_IMPL > NUM_USER
        || USER_BYTES < 1 || USER_BYTES > USER_BYTES_MAX) begin : g_bad_param
        $error("power_device_info_store: unsupported parameter value");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} state_e;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic kind_e decode(input logic [7:0] c);
        logic [7:0] u;
        u = c - CMD_USER_FIRST;
        if (c == CMD_REVISION) begin
            return K_REV;
        end else if (c >= CMD_STR_FIRST && c < CMD_STR_FIRST + 8'(NUM_STR)) begin
            return K_STR;
        end else if (c >= CMD_RATE_FIRST && c < CMD_RATE_FIRST + 8'h0A) begin
            return K_RATE;
        end else if (c >= CMD_USER_FIRST && u < 8'h10) begin
            // Unbuilt user blocks answer as unsupported
            return (u < 8'(USER_IMPL)) ? K_USER : K_BAD;
        end else if (c >= CMD_MAKER_FIRST && c <= CMD_MAKER_LAST) begin
            return K_BAD;
        end else if (c == CMD_MAKER_EXT || c == CMD_PROTO_EXT) begin
            return K_EXT;
        end
        return K_NONE;
    endfunction

    function automatic logic [4:0] slot_of(input logic [7:0] c);
        logic [7:0] o;
        if (c >= CMD_USER_FIRST) begin
            o = c - CMD_USER_FIRST;
        end else if (c >= CMD_RATE_FIRST) begin
            o = c - CMD_RATE_FIRST;
        end else begin
            o = c - CMD_STR_FIRST;
        end
        return o[4:0];
    endfunction

    function automatic logic [15:0] pool_other(input logic [NUM_STR-1:0][7:0] len,
                                               input logic [NUM_STR-1:0] used,
                                               input logic [4:0] skip);
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < NUM_STR; i++) begin
            if (used[i] && 5'(i) != skip) begin
                s = s + 16'(len[i]) + 16'h0001;
            end
        end
        return s;
    endfunction

    function automatic logic [AW-1:0] mem_addr(input kind_e k, input logic [4:0] i, input logic [8:0] off);
        int a;
        if (k == K_STR) begin
            a = int'(i) * SLOT + int'(off);
        end else begin
            a = NUM_STR * SLOT + int'(i) * USER_BYTES + int'(off);
        end
        return AW'(a);
    endfunction

    // ****************************************
    // State
    // ****************************************
    state_e state_q, state_d;
    kind_e kind_q, kind_d;
    logic [4:0] idx_q, idx_d;
    logic [8:0] cnt_q, cnt_d;
    logic [7:0] need_q, need_d;
    logic ok_q, ok_d;
    logic [7:0] rev_q, rev_d;
    logic [NUM_STR-1:0][7:0] str_len_q, str_len_d;
    logic [NUM_STR-1:0] str_used_q, str_used_d;
    logic [NUM_RATE-1:0][15:0] rate_q, rate_d;
    logic [15:0] hold_q, hold_d;
    logic [USER_IMPL-1:0][7:0] user_len_q, user_len_d;
    logic bad_cmd_q, bad_cmd_d;
    logic bad_data_q, bad_data_d;
    logic rd_valid_q, rd_valid_d;
    logic rd_mem_q, rd_mem_d;
    logic [7:0] rd_reg_q, rd_reg_d;
    logic mem_we;
    logic [AW-1:0] mem_waddr;
    logic [AW-1:0] mem_raddr;
    logic [7:0] mem_rdata;
    logic [7:0] blk_len;
    kind_e start_kind;

    assign start_kind = decode(xfer_cmd);
    assign blk_len = (kind_q == K_STR) ? (str_used_q[idx_q[2:0]] ? str_len_q[idx_q[2:0]] : 8'h00)
                                       : user_len_q[idx_q[$clog2(USER_IMPL+1)-1:0]];

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        idx_d = idx_q;
        cnt_d = cnt_q;
        need_d = need_q;
        ok_d = ok_q;
        rev_d = rev_q;
        str_len_d = str_len_q;
        str_used_d = str_used_q;
        rate_d = rate_q;
        hold_d = hold_q;
        user_len_d = user_len_q;
        bad_cmd_d = bad_cmd_q;
        bad_data_d = bad_data_q;
        rd_valid_d = 1'b0;
        rd_mem_d = 1'b0;
        rd_reg_d = rd_reg_q;
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_raddr = '0;
        // Clear first so that a flag set in the same cycle survives
        if (cml_clear) begin
            bad_cmd_d = 1'b0;
            bad_data_d = 1'b0;
        end
        if (xfer_start) begin
            kind_d = start_kind;
            idx_d = slot_of(xfer_cmd);
            cnt_d = 9'h000;
            need_d = 8'h00;
            ok_d = 1'b0;
            state_d = (start_kind == K_NONE) ? ST_IDLE : (xfer_write ? ST_WRITE : ST_READ);
            if (start_kind == K_BAD || start_kind == K_EXT) begin
                bad_cmd_d = 1'b1;
            end
        end else if (state_q == ST_WRITE && wr_valid) begin
            if (cnt_q != 9'h1FF) begin
                cnt_d = cnt_q + 9'h001;
            end
            case (kind_q)
                K_REV: begin
                    if (cnt_q != 9'h000 || REV_READ_ONLY) begin
                        bad_data_d = 1'b1;
                    end else begin
                        rev_d = wr_byte;
                    end
                end
                K_RATE: begin
                    if (cnt_q == 9'h000) begin
                        hold_d[7:0] = wr_byte;
                    end else if (cnt_q == 9'h001) begin
                        hold_d[15:8] = wr_byte;
                    end else begin
                        bad_data_d = 1'b1;
                    end
                end
                K_STR, K_USER: begin
                    if (cnt_q == 9'h000) begin
                        // Count byte is charged to the pool along with the data
                        if (kind_q == K_STR && pool_other(str_len_q, str_used_q, idx_q) + 16'(wr_byte)
                            + 16'h0001 <= 16'(INV_POOL)) begin
                            ok_d = 1'b1;
                            need_d = wr_byte;
                            str_len_d[idx_q[2:0]] = 8'h00;
                            str_used_d[idx_q[2:0]] = 1'b1;
                        end else if (kind_q == K_USER && 9'(wr_byte) <= 9'(USER_BYTES)) begin
                            ok_d = 1'b1;
                            need_d = wr_byte;
                            user_len_d[idx_q[$clog2(USER_IMPL+1)-1:0]] = 8'h00;
                        end else begin
                            bad_data_d = 1'b1;
                        end
                    end else if (ok_q && cnt_q <= {1'b0, need_q}) begin
                        mem_we = 1'b1;
                        mem_waddr = mem_addr(kind_q, idx_q, cnt_q - 9'h001);
                        if (kind_q == K_STR) begin
                            str_len_d[idx_q[2:0]] = cnt_q[7:0];
                        end else begin
                            user_len_d[idx_q[$clog2(USER_IMPL+1)-1:0]] = cnt_q[7:0];
                        end
                    end else begin
                        bad_data_d = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (state_q == ST_WRITE && xfer_stop) begin
            state_d = ST_IDLE;
            if (kind_q == K_RATE) begin
                if (cnt_q == 9'(RATE_BYTES)) begin
                    rate_d[idx_q[3:0]] = hold_q;
                end else begin
                    bad_data_d = 1'b1;
                end
            end else if ((kind_q == K_STR || kind_q == K_USER) && ok_q && cnt_q <= {1'b0, need_q}) begin
                bad_data_d = 1'b1;
            end
        end else if (state_q == ST_READ && rd_req) begin
            rd_valid_d = 1'b1;
            if (cnt_q != 9'h1FF) begin
                cnt_d = cnt_q + 9'h001;
            end
            rd_reg_d = EMPTY_BYTE;
            case (kind_q)
                K_REV: begin
                    if (cnt_q == 9'h000) begin
                        rd_reg_d = rev_q;
                    end
                end
                K_RATE: begin
                    if (cnt_q == 9'h000) begin
                        rd_reg_d = rate_q[idx_q[3:0]][7:0];
                    end else if (cnt_q == 9'h001) begin
                        rd_reg_d = rate_q[idx_q[3:0]][15:8];
                    end
                end
                K_STR, K_USER: begin
                    if (cnt_q == 9'h000) begin
                        rd_reg_d = blk_len;
                    end else if (cnt_q <= {1'b0, blk_len}) begin
                        rd_mem_d = 1'b1;
                        mem_raddr = mem_addr(kind_q, idx_q, cnt_q - 9'h001);
                    end
                end
                default: begin
                end
            endcase
        end else if (state_q == ST_READ && xfer_stop) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            kind_q <= K_NONE;
            idx_q <= 5'h00;
            cnt_q <= 9'h000;
            need_q <= 8'h00;
            ok_q <= 1'b0;
            rev_q <= {REV_LINK_RESET, REV_LANG_RESET};
            str_len_q <= '0;
            str_used_q <= '0;
            rate_q <= '0;
            hold_q <= 16'h0000;
            user_len_q <= '0;
            bad_cmd_q <= 1'b0;
            bad_data_q <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_mem_q <= 1'b0;
            rd_reg_q <= 8'h00;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            idx_q <= idx_d;
            cnt_q <= cnt_d;
            need_q <= need_d;
            ok_q <= ok_d;
            rev_q <= rev_d;
            str_len_q <= str_len_d;
            str_used_q <= str_used_d;
            rate_q <= rate_d;
            hold_q <= hold_d;
            user_len_q <= user_len_d;
            bad_cmd_q <= bad_cmd_d;
            bad_data_q <= bad_data_d;
            rd_valid_q <= rd_valid_d;
            rd_mem_q <= rd_mem_d;
            rd_reg_q <= rd_reg_d;
        end
    end

    info_byte_store #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_store (
        .ref_clk(ref_clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(wr_byte),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // ****************************************
    // Outputs
    // ****************************************
    // Ratings feed no comparator and raise no flag
    assign rd_valid = rd_valid_q;
    assign rd_byte = rd_mem_q ? mem_rdata : rd_reg_q;
    assign cmd_hit = (state_q != ST_IDLE);
    assign cml_flags = {bad_cmd_q, bad_data_q, 6'h00};

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence rd_issue_s;
        state_q == ST_READ && rd_req && !xfer_start;
    endsequence

    sequence rate_word_s;
        state_q == ST_WRITE && kind_q == K_RATE && !xfer_start && xfer_stop && cnt_q == 9'h002;
    endsequence

    rd_answer_a: assert property (rd_issue_s |=> rd_valid ##1 !rd_valid || $past(rd_req))
        else $error("read request not answered next cycle");
    rev_locked_a: assert property (state_q == ST_WRITE && kind_q == K_REV && wr_valid && !xfer_start
        && REV_READ_ONLY |=> $stable(rev_q) && bad_data_q)
        else $error("read-only revision changed or not flagged");
    blk_count_a: assert property (rd_issue_s and (kind_q == K_STR || kind_q == K_USER) && cnt_q == 9'h000
        |=> rd_byte == $past(blk_len))
        else $error("block read did not lead with stored count");
    pool_bound_a: assert property (pool_other(str_len_q, str_used_q, 5'h1F) <= 16'(INV_POOL))
        else $error("inventory pool overcommitted");
    pool_reject_a: assert property (state_q == ST_WRITE && kind_q == K_STR && wr_valid && !xfer_start
        && cnt_q == 9'h000 && pool_other(str_len_q, str_used_q, idx_q) + 16'(wr_byte) >= 16'(INV_POOL)
        |=> bad_data_q && !ok_q)
        else $error("oversize inventory entry accepted");
    rate_commit_a: assert property (rate_word_s |=> rate_q[$past(idx_q[3:0])] == $past(hold_q))
        else $error("rating word not stored");
    rate_short_a: assert property (state_q == ST_WRITE && kind_q == K_RATE && !xfer_start && xfer_stop
        && cnt_q != 9'h002 |=> bad_data_q && $stable(rate_q))
        else $error("rating with wrong byte count accepted");
    user_bound_a: assert property (state_q == ST_WRITE && kind_q == K_USER && ok_q |-> blk_len <= need_q)
        else $error("user block exceeds its size");
    bad_cmd_a: assert property (xfer_start && (start_kind == K_BAD || start_kind == K_EXT)
        |=> bad_cmd_q ##1 (bad_cmd_q || $past(cml_clear)))
        else $error("unsupported command not flagged");
    flag_keep_a: assert property (bad_data_q && !cml_clear |=> bad_data_q)
        else $error("data flag dropped without clear");

endmodule

`default_nettype wire

// *** src/info_store_pkg.sv ***
// Constants and types shared by the device information store
`default_nettype none

package info_store_pkg;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_REVISION = 8'h98;
    localparam logic [7:0] CMD_STR_FIRST = 8'h99;
    localparam logic [7:0] CMD_RATE_FIRST = 8'hA0;
    localparam logic [7:0] CMD_USER_FIRST = 8'hB0;
    localparam logic [7:0] CMD_MAKER_FIRST = 8'hD0;
    localparam logic [7:0] CMD_MAKER_LAST = 8'hFD;
    localparam logic [7:0] CMD_MAKER_EXT = 8'hFE;
    localparam logic [7:0] CMD_PROTO_EXT = 8'hFF;

    // ****************************************
    // Counts and sizes
    // ****************************************
    localparam int NUM_STR = 6;
    localparam int NUM_RATE = 10;
    localparam int NUM_USER = 16;
    localparam int USER_BYTES_MAX = 255;
    localparam int USER_TOTAL_MAX = 4080;
    localparam int RATE_BYTES = 2;

    // ****************************************
    // Revision byte layout and reset value
    // ****************************************
    localparam int REV_LINK_MSB = 7;
    localparam int REV_LINK_LSB = 5;
    localparam int REV_LANG_MSB = 4;
    localparam int REV_LANG_LSB = 0;
    // Arbitrary neutral revision figures
    localparam logic [2:0] REV_LINK_RESET = 3'h1;
    localparam logic [4:0] REV_LANG_RESET = 5'h02;

    // ****************************************
    // Status byte and fill value
    // ****************************************
    localparam int CML_BAD_CMD = 7;
    localparam int CML_BAD_DATA = 6;
    localparam logic [7:0] EMPTY_BYTE = 8'hFF;

    typedef enum logic [2:0] {K_NONE, K_REV, K_STR, K_RATE, K_USER, K_BAD, K_EXT} kind_e;

endpackage

`default_nettype wire

// *** src/info_byte_store.sv ***
// Flip-flop byte storage with one write port and one registered read port
`default_nettype none

module info_byte_store #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic ref_clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);

    // No reset: contents are only read after being written
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rdata_q;

    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
        rdata_q <= mem_q[raddr];
    end

    assign rdata = rdata_q;

endmodule

`default_nettype wire

// *** bench/smbus_host_model.sv ***
// Host side of the store's command transaction port, driven on falling edges
`default_nettype none

module smbus_host_model (
    input wire logic ref_clk,
    output logic xfer_start,
    output logic [7:0] xfer_cmd,
    output logic xfer_write,
    output logic wr_valid,
    output logic [7:0] wr_byte,
    output logic xfer_stop,
    output logic rd_req,
    output logic cml_clear,
    input wire logic rd_valid,
    input wire logic [7:0] rd_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Every task starts and ends just after a falling edge
    // ****************************************
    initial begin
        {xfer_start, xfer_cmd, xfer_write, wr_valid, wr_byte, xfer_stop, rd_req, cml_clear} = '0;
    end

    task automatic begin_xfer(input logic [7:0] cmd, input logic wr);
        xfer_start = 1'b1;
        xfer_cmd = cmd;
        xfer_write = wr;
        @(negedge ref_clk);
        xfer_start = 1'b0;
    endtask

    // Valid stays up so consecutive bytes go back to back
    task automatic put(input logic [7:0] b);
        wr_valid = 1'b1;
        wr_byte = b;
        @(negedge ref_clk);
    endtask

    // Answer stands one cycle only, so it is taken at the next falling edge
    task automatic get(output logic [7:0] b);
        rd_req = 1'b1;
        @(negedge ref_clk);
        rd_req = 1'b0;
        b = (rd_valid === 1'b1) ? rd_byte : 8'hXX;
        @(negedge ref_clk);
    endtask

    // Stop never shares a cycle with a data byte
    task automatic end_xfer();
        wr_valid = 1'b0;
        xfer_stop = 1'b1;
        @(negedge ref_clk);
        xfer_stop = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic clear_flags();
        cml_clear = 1'b1;
        @(negedge ref_clk);
        cml_clear = 1'b0;
        @(negedge ref_clk);
    endtask
endmodule

`default_nettype wire

// *** bench/power_device_info_store_tb.sv ***
// Self-checking bench for the device information store
`default_nettype none

module power_device_info_store_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import info_store_pkg::*;

    localparam int POOL = 24;
    localparam int LIMIT = 10000;
    localparam logic [7:0] F_CMD = 8'(1 << CML_BAD_CMD);
    localparam logic [7:0] F_DATA = 8'(1 << CML_BAD_DATA);

    logic ref_clk, rst_n, xfer_start, xfer_write, wr_valid, xfer_stop, rd_req, cml_clear;
    logic rd_valid, cmd_hit;
    logic [7:0] xfer_cmd, wr_byte, rd_byte, cml_flags;
    logic [7:0] cnt [NUM_STR];
    logic [7:0] bas [NUM_STR];
    int fails = 0;
    int compares = 0;
    int cycles = 0;

    power_device_info_store #(.INV_POOL(POOL), .USER_IMPL(2), .USER_BYTES(255), .REV_READ_ONLY(1'b1))
    u_power_device_info_store (.ref_clk(ref_clk), .rst_n(rst_n), .xfer_start(xfer_start), .xfer_cmd(xfer_cmd),
        .xfer_write(xfer_write), .wr_valid(wr_valid), .wr_byte(wr_byte), .xfer_stop(xfer_stop), .rd_req(rd_req),
        .rd_valid(rd_valid), .rd_byte(rd_byte), .cmd_hit(cmd_hit), .cml_clear(cml_clear), .cml_flags(cml_flags));

    smbus_host_model u_smbus_host_model (.ref_clk(ref_clk), .xfer_start(xfer_start), .xfer_cmd(xfer_cmd),
        .xfer_write(xfer_write), .wr_valid(wr_valid), .wr_byte(wr_byte), .xfer_stop(xfer_stop), .rd_req(rd_req),
        .cml_clear(cml_clear), .rd_valid(rd_valid), .rd_byte(rd_byte));

    // ****************************************
    // Clock, timeout and verdict
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            give_verdict();
        end
    end

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Flags are sticky, so a late set still shows; clear is checked too
    task automatic flags(input logic [7:0] exp);
        @(negedge ref_clk);
        check8("status flags", exp, cml_flags);
        u_smbus_host_model.clear_flags();
        check8("flags cleared", 8'h00, cml_flags);
    endtask

    task automatic wr_block(input logic [7:0] cmd, input logic [7:0] n, input int sent, input logic [7:0] base);
        u_smbus_host_model.begin_xfer(cmd, 1'b1);
        check8("command hit", 8'h01, {7'h00, cmd_hit});
        u_smbus_host_model.put(n);
        for (int i = 0; i < sent; i++) begin
            u_smbus_host_model.put(8'(base + i));
        end
        u_smbus_host_model.end_xfer();
    endtask

    task automatic rd_block(input logic [7:0] cmd, input logic [7:0] n, input logic [7:0] base);
        logic [7:0] b;
        u_smbus_host_model.begin_xfer(cmd, 1'b0);
        u_smbus_host_model.get(b);
        check8("block count", n, b);
        for (int i = 0; i < n; i++) begin
            u_smbus_host_model.get(b);
            check8("block byte", 8'(base + i), b);
        end
        u_smbus_host_model.end_xfer();
    endtask

    task automatic wr_word(input logic [7:0] cmd, input logic [15:0] w, input int nb);
        u_smbus_host_model.begin_xfer(cmd, 1'b1);
        for (int i = 0; i < nb; i++) begin
            u_smbus_host_model.put(i == 0 ? w[7:0] : (i == 1 ? w[15:8] : 8'h5A));
        end
        u_smbus_host_model.end_xfer();
    endtask

    task automatic rd_bytes(input logic [7:0] cmd, input logic [15:0] w, input int nb);
        logic [7:0] b;
        u_smbus_host_model.begin_xfer(cmd, 1'b0);
        for (int i = 0; i < nb; i++) begin
            u_smbus_host_model.get(b);
            check8("read byte", i == 0 ? w[7:0] : w[15:8], b);
        end
        u_smbus_host_model.end_xfer();
    endtask

    task automatic put_str(input int i, input logic [7:0] n, input logic [7:0] nb);
        wr_block(CMD_STR_FIRST + 8'(i), n, n, nb);
        cnt[i] = n;
        bas[i] = nb;
    endtask

    task automatic rd_all();
        for (int i = 0; i < NUM_STR; i++) begin
            rd_block(CMD_STR_FIRST + 8'(i), cnt[i], bas[i]);
        end
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        rst_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        check8("reset outputs", 8'h00, {6'h00, rd_valid, cmd_hit});
        check8("reset flags", 8'h00, cml_flags);
        rd_bytes(CMD_REVISION, {8'h00, REV_LINK_RESET, REV_LANG_RESET}, 1);
        wr_word(CMD_REVISION, 16'h0000, 1);
        flags(F_DATA);
        rd_bytes(CMD_REVISION, {8'h00, REV_LINK_RESET, REV_LANG_RESET}, 1);
        $display("test revision done");

        for (int i = 0; i < NUM_STR; i++) begin
            cnt[i] = 8'h00;
            bas[i] = 8'h00;
        end
        rd_all();
        for (int i = 0; i < NUM_STR; i++) begin
            put_str(i, 8'h02, i == 4 ? 8'h30 : 8'(8'h41 + 4 * i));
        end
        rd_all();
        // Pool use climbs 18, 21, 23, 24: the last lands exactly on the pool size
        put_str(5, 8'h05, 8'h50);
        put_str(1, 8'h04, 8'h60);
        put_str(0, 8'h03, 8'h70);
        flags(8'h00);
        wr_block(CMD_STR_FIRST + 8'h03, 8'h03, 3, 8'h61);
        flags(F_DATA);
        wr_block(CMD_STR_FIRST + 8'h02, 8'h02, 4, 8'h61);
        flags(F_DATA);
        bas[2] = 8'h61;
        // Pool still fits a count of two, so the short entry is taken and ends with one byte, a charge of two
        wr_block(CMD_STR_FIRST + 8'h03, 8'h02, 1, 8'h71);
        flags(F_DATA);
        cnt[3] = 8'h01;
        bas[3] = 8'h71;
        rd_all();
        $display("test inventory done");

        rd_bytes(CMD_RATE_FIRST, 16'h0000, 2);
        for (int i = 0; i < NUM_RATE; i++) begin
            wr_word(CMD_RATE_FIRST + 8'(i), {8'(8'hC0 + i), 8'(i)}, RATE_BYTES);
        end
        flags(8'h00);
        for (int i = 0; i < NUM_RATE; i++) begin
            rd_bytes(CMD_RATE_FIRST + 8'(i), {8'(8'hC0 + i), 8'(i)}, RATE_BYTES);
        end
        wr_word(CMD_RATE_FIRST + 8'h03, 16'hBEEF, 1);
        flags(F_DATA);
        wr_word(CMD_RATE_FIRST + 8'h03, 16'hBEEF, 3);
        flags(F_DATA);
        rd_bytes(CMD_RATE_FIRST + 8'h03, 16'hC303, RATE_BYTES);
        $display("test ratings done");

        wr_block(CMD_USER_FIRST, 8'hFF, USER_BYTES_MAX, 8'h01);
        wr_block(CMD_USER_FIRST + 8'h01, 8'h03, 3, 8'hA0);
        flags(8'h00);
        rd_block(CMD_USER_FIRST, 8'hFF, 8'h01);
        rd_block(CMD_USER_FIRST + 8'h01, 8'h03, 8'hA0);
        rd_bytes(CMD_USER_FIRST + 8'h02, {8'h00, EMPTY_BYTE}, 1);
        flags(F_CMD);
        $display("test user data done");

        for (int c = CMD_MAKER_FIRST; c <= CMD_PROTO_EXT; c++) begin
            rd_bytes(8'(c), {8'h00, EMPTY_BYTE}, 1);
            flags(F_CMD);
        end
        u_smbus_host_model.begin_xfer(8'h20, 1'b1);
        check8("foreign hit", 8'h00, {7'h00, cmd_hit});
        u_smbus_host_model.put(8'h11);
        u_smbus_host_model.end_xfer();
        flags(8'h00);
        $display("test command codes done");
        give_verdict();
    end
endmodule

`default_nettype wire
